/* hdl/cfd_config_loader.sv */
// configuration fuse store, axi4-lite access, power-on latch of clock settings
`timescale 1ns/1ns
// Functional notes
// - seven sixteen-bit fuse words, bitwise writable
// - system bits set power-on state; protection blocks access
// - switch/monitor field: 1x off, 01, 00
// - reset source: primary, lprc, fast rc, 32k
// - codes f..c external clock, pll 16/8/4/none
// - code b external clock, pin drives fosc/4
// - code 9 rc with clkout, 8 pin free
// - codes 7..4 medium crystal, pll 16/8/4/none
// - 001x high-speed, 000x low-frequency crystal
// - eeprom readback returns stored contents for compare
module cfd_config_loader (
  // clock and reset
  input  wire logic                  clk_in,
  input  wire logic                  rst_in,
  // axi4-lite write address
  input  wire logic                  s_axi_awvalid_in,
  output logic                       s_axi_awready_out,
  input  wire logic [5:0]            s_axi_awaddr_in,
  // axi4-lite write data
  input  wire logic                  s_axi_wvalid_in,
  output logic                       s_axi_wready_out,
  input  wire logic [31:0]           s_axi_wdata_in,
  input  wire logic [3:0]            s_axi_wstrb_in,
  // axi4-lite write response
  output logic                       s_axi_bvalid_out,
  input  wire logic                  s_axi_bready_in,
  output logic [1:0]                 s_axi_bresp_out,
  // axi4-lite read address
  input  wire logic                  s_axi_arvalid_in,
  output logic                       s_axi_arready_out,
  input  wire logic [5:0]            s_axi_araddr_in,
  // axi4-lite read data
  output logic                       s_axi_rvalid_out,
  input  wire logic                  s_axi_rready_in,
  output logic [31:0]                s_axi_rdata_out,
  output logic [1:0]                 s_axi_rresp_out,
  // data eeprom read-back port
  output logic [9:0]                 ee_addr_out,
  input  wire logic [7:0]            ee_data_in,
  // latched clock settings, plus live code-protect state
  output cfd_pkg::cfd_src_type       reset_src_out,
  output cfd_pkg::cfd_mode_type      mode_out,
  output logic [4:0]                 pll_mult_out,
  output logic                       switch_en_out,
  output logic                       monitor_en_out,
  output logic                       second_pin_clkout_out,
  output logic                       code_protect_out,
  output logic                       settings_valid_out
);
  ////////////////////////////////////////////////////////////////////////
  // fuse words and control state
  logic [15:0]  cfg_word [cfd_pkg::NUM_WORDS];
  logic         protect;
  logic [2:0]   rd_index;
  logic [9:0]   ee_addr;
  logic [5:0]   load_count;
  logic         loaded;
  logic         reserved_seen;
  logic [15:0]  latched_word;

  ////////////////////////////////////////////////////////////////////////
  // write channel: take address and data in either order
  logic         aw_held;
  logic [5:0]   aw_addr;
  logic         w_held;
  logic [31:0]  w_data;
  logic [3:0]   w_strb;
  logic         do_write;
  logic [5:0]   wr_addr;
  logic [31:0]  wr_data;
  logic [3:0]   wr_strb;
  logic [2:0]   wr_word;
  logic         wr_is_word;
  logic         wr_is_ctrl;
  logic         wr_ok;

  assign s_axi_awready_out = ~aw_held & ~s_axi_bvalid_out;
  assign s_axi_wready_out  = ~w_held & ~s_axi_bvalid_out;
  assign wr_addr  = aw_held ? aw_addr : s_axi_awaddr_in;
  assign wr_data  = w_held ? w_data : s_axi_wdata_in;
  assign wr_strb  = w_held ? w_strb : s_axi_wstrb_in;
  assign do_write = (aw_held | (s_axi_awvalid_in & s_axi_awready_out)) &
                    (w_held | (s_axi_wvalid_in & s_axi_wready_out));
  assign wr_word    = wr_addr[4:2];
  assign wr_is_word = (wr_addr[5] == 1'b0) && (wr_word < 3'h7) && (wr_addr[1:0] == 2'h0);
  assign wr_is_ctrl = (wr_addr == cfd_pkg::ADDR_CTRL);
  // protected store refuses writes to fuse words
  assign wr_ok      = (wr_is_word & ~protect) | wr_is_ctrl;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      aw_held <= 1'b0;
      aw_addr <= 6'h00;
      w_held  <= 1'b0;
      w_data  <= 32'h00000000;
      w_strb  <= 4'h0;
    end else begin
      if (do_write) begin
        aw_held <= 1'b0;
        w_held  <= 1'b0;
      end else begin
        if (s_axi_awvalid_in && s_axi_awready_out) begin
          aw_held <= 1'b1;
          aw_addr <= s_axi_awaddr_in;
        end
        if (s_axi_wvalid_in && s_axi_wready_out) begin
          w_held <= 1'b1;
          w_data <= s_axi_wdata_in;
          w_strb <= s_axi_wstrb_in;
        end
      end
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out  <= cfd_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid_out <= 1'b1;
      s_axi_bresp_out  <= wr_ok ? cfd_pkg::RESP_OKAY : cfd_pkg::RESP_SLVERR;
    end else if (s_axi_bready_in) begin
      s_axi_bvalid_out <= 1'b0;
    end
  end

  // each fuse word, each byte lane individually; bits set or cleared freely
  genvar gi;
  generate
    for (gi = 0; gi < cfd_pkg::NUM_WORDS; gi++) begin : g_word
      always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
          cfg_word[gi] <= cfd_pkg::WORD_RESET;
        end else if (do_write && wr_is_word && !protect && wr_word == 3'(gi)) begin
          if (wr_strb[0]) cfg_word[gi][7:0]  <= wr_data[7:0];
          if (wr_strb[1]) cfg_word[gi][15:8] <= wr_data[15:8];
        end
      end
    end
  endgenerate

  // control: sticky protect bit and read-back index
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      protect  <= 1'b0;
      rd_index <= 3'h0;
    end else if (do_write && wr_is_ctrl && wr_strb[0]) begin
      protect  <= protect | wr_data[cfd_pkg::CTRL_PROT_BIT];
      rd_index <= wr_data[cfd_pkg::CTRL_RDIDX_LSB +: 3];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // power-on latch: settings sampled once after reset release
  logic load_done;
  assign load_done = (load_count == 6'(cfd_pkg::LOAD_CYCLES));

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      load_count   <= 6'h00;
      loaded       <= 1'b0;
      latched_word <= cfd_pkg::WORD_RESET;
    end else if (!loaded) begin
      load_count <= load_count + 6'h01;
      if (load_done) begin
        loaded       <= 1'b1;
        latched_word <= cfg_word[0];
      end
    end
  end

  cfd_osc_decode u_decode (
    .osc_word_in           (latched_word),
    .reset_src_out         (reset_src_out),
    .mode_out              (mode_out),
    .pll_mult_out          (pll_mult_out),
    .switch_en_out         (switch_en_out),
    .monitor_en_out        (monitor_en_out),
    .second_pin_clkout_out (second_pin_clkout_out),
    .reserved_code_out     (reserved_seen)
  );

  assign settings_valid_out = loaded;
  assign code_protect_out   = protect;

  ////////////////////////////////////////////////////////////////////////
  // read channel: one read at a time, answered one cycle after address
  logic         rd_take;
  logic [2:0]   rd_word;
  logic         rd_is_word;
  logic [31:0]  rd_value;
  logic [1:0]   rd_resp;

  assign s_axi_arready_out = ~s_axi_rvalid_out;
  assign rd_take    = s_axi_arvalid_in & s_axi_arready_out;
  assign rd_word    = s_axi_araddr_in[4:2];
  assign rd_is_word = (s_axi_araddr_in[5] == 1'b0) && (rd_word < 3'h7) && (s_axi_araddr_in[1:0] == 2'h0);
  // protection hides fuse contents from readers
  assign rd_value =
    rd_is_word ? (protect ? 32'h00000000 : {16'h0000, cfg_word[rd_word]}) :
    (s_axi_araddr_in == cfd_pkg::ADDR_CTRL) ? {25'h0, rd_index, 2'h0, protect, 1'b0} :
    (s_axi_araddr_in == cfd_pkg::ADDR_STATUS) ? {25'h0, reserved_seen, pll_mult_out, loaded} :
    (s_axi_araddr_in == cfd_pkg::ADDR_READBACK) ? {14'h0, ee_addr, ee_data_in} :
    32'h00000000;
  assign rd_resp = (rd_is_word || s_axi_araddr_in == cfd_pkg::ADDR_CTRL ||
                    s_axi_araddr_in == cfd_pkg::ADDR_STATUS ||
                    s_axi_araddr_in == cfd_pkg::ADDR_READBACK) ? cfd_pkg::RESP_OKAY : cfd_pkg::RESP_SLVERR;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out  <= 32'h00000000;
      s_axi_rresp_out  <= cfd_pkg::RESP_OKAY;
    end else if (rd_take) begin
      s_axi_rvalid_out <= 1'b1;
      s_axi_rdata_out  <= rd_value;
      s_axi_rresp_out  <= rd_resp;
    end else if (s_axi_rready_in) begin
      s_axi_rvalid_out <= 1'b0;
    end
  end

  // read-back pointer advances after each read-back read, for sequential compare; a read-back write in the same cycle loads it instead
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ee_addr <= 10'h000;
    end else if (do_write && wr_addr == cfd_pkg::ADDR_READBACK) begin
      ee_addr <= wr_data[17:8];
    end else if (rd_take && s_axi_araddr_in == cfd_pkg::ADDR_READBACK) begin
      ee_addr <= ee_addr + 10'h001;
    end
  end
  assign ee_addr_out = ee_addr;

  ////////////////////////////////////////////////////////////////////////
  // checks
  a_settings_hold: assert property (@(posedge clk_in) disable iff (rst_in)
    loaded |=> $stable(latched_word))
    else $error("clock settings changed after power-on load");
  a_load_time: assert property (@(posedge clk_in) disable iff (rst_in)
    $rose(loaded) |-> $past(load_count) == 6'(cfd_pkg::LOAD_CYCLES))
    else $error("settings loaded at wrong time");
  a_monitor_needs: assert property (@(posedge clk_in) disable iff (rst_in)
    monitor_en_out |-> switch_en_out && latched_word[15:14] == 2'h0)
    else $error("monitor enabled without switching");
  a_source_map: assert property (@(posedge clk_in) disable iff (rst_in)
    (latched_word[9:8] == 2'h3) |-> reset_src_out == cfd_pkg::SRC_PRIMARY)
    else $error("primary source not selected");
  a_ext_pll: assert property (@(posedge clk_in) disable iff (rst_in)
    (latched_word[3:0] == 4'hf) |-> pll_mult_out == 5'h10 && !second_pin_clkout_out)
    else $error("external clock pll 16 decode wrong");
  a_ext_clkout: assert property (@(posedge clk_in) disable iff (rst_in)
    (latched_word[3:0] == 4'hb) |-> second_pin_clkout_out && mode_out == cfd_pkg::MODE_EXT_CLK_OUT)
    else $error("external clock output decode wrong");
  a_rc_modes: assert property (@(posedge clk_in) disable iff (rst_in)
    (latched_word[3:1] == 3'h4) |-> second_pin_clkout_out == latched_word[0])
    else $error("rc clock output decode wrong");
  a_crystal_pll: assert property (@(posedge clk_in) disable iff (rst_in)
    (latched_word[3:0] == 4'h6) |-> mode_out == cfd_pkg::MODE_MED_CRYSTAL && pll_mult_out == 5'h08)
    else $error("crystal pll 8 decode wrong");
  a_low_bit_free: assert property (@(posedge clk_in) disable iff (rst_in)
    (latched_word[3:1] == 3'h1) |-> mode_out == cfd_pkg::MODE_HS_CRYSTAL)
    else $error("high-speed crystal decode wrong");
  a_protect_read: assert property (@(posedge clk_in) disable iff (rst_in)
    (rd_take && protect && rd_is_word) |=> s_axi_rvalid_out && s_axi_rdata_out == 32'h00000000)
    else $error("protected word leaked");
  a_readback_step: assert property (@(posedge clk_in) disable iff (rst_in)
    (rd_take && s_axi_araddr_in == cfd_pkg::ADDR_READBACK && !do_write) |=> ee_addr == $past(ee_addr) + 10'h001)
    else $error("read-back pointer did not advance");
  // each remaining field code except crystal code 5, reserved 1010 and switch code 00 gets its own check, so one wrong case arm cannot hide behind its neighbours
  a_switch_off: assert property (@(posedge clk_in) disable iff (rst_in)
    latched_word[15] |-> !switch_en_out && !monitor_en_out)
    else $error("switching not disabled for code 1x");
  a_switch_only: assert property (@(posedge clk_in) disable iff (rst_in)
    (latched_word[15:14] == 2'h1) |-> switch_en_out && !monitor_en_out)
    else $error("switch-only decode wrong");
  a_source_lprc: assert property (@(posedge clk_in) disable iff (rst_in)
    (latched_word[9:8] == 2'h2) |-> reset_src_out == cfd_pkg::SRC_LPRC)
    else $error("low-power rc source not selected");
  a_source_frc: assert property (@(posedge clk_in) disable iff (rst_in)
    (latched_word[9:8] == 2'h1) |-> reset_src_out == cfd_pkg::SRC_FAST_RC)
    else $error("fast rc source not selected");
  a_source_sec: assert property (@(posedge clk_in) disable iff (rst_in)
    (latched_word[9:8] == 2'h0) |-> reset_src_out == cfd_pkg::SRC_SEC_32K)
    else $error("secondary source not selected");
  a_ext_pll8: assert property (@(posedge clk_in) disable iff (rst_in)
    (latched_word[3:0] == 4'he) |-> pll_mult_out == 5'h08 && mode_out == cfd_pkg::MODE_EXT_CLK_PIN_FREE)
    else $error("external clock pll 8 decode wrong");
  a_ext_pll4: assert property (@(posedge clk_in) disable iff (rst_in)
    (latched_word[3:0] == 4'hd) |-> pll_mult_out == 5'h04 && !second_pin_clkout_out)
    else $error("external clock pll 4 decode wrong");
  a_ext_nopll: assert property (@(posedge clk_in) disable iff (rst_in)
    (latched_word[3:0] == 4'hc) |-> pll_mult_out == 5'h01 && !second_pin_clkout_out)
    else $error("external clock without pll decode wrong");
  a_crystal_pll16: assert property (@(posedge clk_in) disable iff (rst_in)
    (latched_word[3:0] == 4'h7) |-> mode_out == cfd_pkg::MODE_MED_CRYSTAL && pll_mult_out == 5'h10)
    else $error("crystal pll 16 decode wrong");
  a_crystal_nopll: assert property (@(posedge clk_in) disable iff (rst_in)
    (latched_word[3:0] == 4'h4) |-> mode_out == cfd_pkg::MODE_MED_CRYSTAL && pll_mult_out == 5'h01)
    else $error("crystal without pll decode wrong");
  a_low_freq: assert property (@(posedge clk_in) disable iff (rst_in)
    (latched_word[3:1] == 3'h0) |-> mode_out == cfd_pkg::MODE_LF_CRYSTAL)
    else $error("low-frequency crystal decode wrong");
  a_bresp_hold: assert property (@(posedge clk_in) disable iff (rst_in)
    (s_axi_bvalid_out && !s_axi_bready_in) |=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
    else $error("write response dropped before taken");
  a_rdata_hold: assert property (@(posedge clk_in) disable iff (rst_in)
    (s_axi_rvalid_out && !s_axi_rready_in) |=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
    else $error("read data dropped before taken");
  a_protect_write: assert property (@(posedge clk_in) disable iff (rst_in)
    (do_write && wr_is_word && protect) |=> s_axi_bresp_out == cfd_pkg::RESP_SLVERR)
    else $error("protected write not refused");
  a_load_once: assert property (@(posedge clk_in) disable iff (rst_in)
    loaded |=> loaded)
    else $error("settings valid dropped without reset");
endmodule

/* hdl/cfd_osc_decode.sv */
// oscillator configuration word decoder
`timescale 1ns/1ns
module cfd_osc_decode (
  // encoded word
  input  wire logic [15:0]         osc_word_in,
  // decoded clock settings
  output cfd_pkg::cfd_src_type     reset_src_out,
  output cfd_pkg::cfd_mode_type    mode_out,
  output logic [4:0]               pll_mult_out,
  output logic                     switch_en_out,
  output logic                     monitor_en_out,
  output logic                     second_pin_clkout_out,
  output logic                     reserved_code_out
);
  logic [1:0] clock_switch_monitor_mode;
  logic [1:0] reset_osc_source_select;
  logic [3:0] primary_osc_mode;

  assign clock_switch_monitor_mode = osc_word_in[cfd_pkg::CKSM_LSB +: 2];
  assign reset_osc_source_select   = osc_word_in[cfd_pkg::FOS_LSB +: 2];
  assign primary_osc_mode          = osc_word_in[cfd_pkg::FPR_LSB +: 4];

  // 1x both off, 01 switch only, 00 both on
  assign switch_en_out  = ~clock_switch_monitor_mode[1];
  assign monitor_en_out = (clock_switch_monitor_mode == 2'h0);

  always_comb begin
    unique case (reset_osc_source_select)
      2'h3: reset_src_out = cfd_pkg::SRC_PRIMARY;
      2'h2: reset_src_out = cfd_pkg::SRC_LPRC;
      2'h1: reset_src_out = cfd_pkg::SRC_FAST_RC;
      2'h0: reset_src_out = cfd_pkg::SRC_SEC_32K;
    endcase
  end

  // reserved 1010 falls back to pin-free external clock; software must never write it
  always_comb begin
    mode_out              = cfd_pkg::MODE_EXT_CLK_PIN_FREE;
    pll_mult_out          = 5'h01;
    second_pin_clkout_out = 1'b0;
    reserved_code_out     = 1'b0;
    unique casez (primary_osc_mode)
      4'hf: pll_mult_out = 5'h10;
      4'he: pll_mult_out = 5'h08;
      4'hd: pll_mult_out = 5'h04;
      4'hc: pll_mult_out = 5'h01;
      4'hb: begin
        mode_out              = cfd_pkg::MODE_EXT_CLK_OUT;
        second_pin_clkout_out = 1'b1;
      end
      4'ha: reserved_code_out = 1'b1;
      4'h9: begin
        mode_out              = cfd_pkg::MODE_EXT_RC_CLKOUT;
        second_pin_clkout_out = 1'b1;
      end
      4'h8: mode_out = cfd_pkg::MODE_EXT_RC_PIN_FREE;
      4'h7: begin
        mode_out     = cfd_pkg::MODE_MED_CRYSTAL;
        pll_mult_out = 5'h10;
      end
      4'h6: begin
        mode_out     = cfd_pkg::MODE_MED_CRYSTAL;
        pll_mult_out = 5'h08;
      end
      4'h5: begin
        mode_out     = cfd_pkg::MODE_MED_CRYSTAL;
        pll_mult_out = 5'h04;
      end
      4'h4: mode_out = cfd_pkg::MODE_MED_CRYSTAL;
      4'b001?: mode_out = cfd_pkg::MODE_HS_CRYSTAL;
      4'b000?: mode_out = cfd_pkg::MODE_LF_CRYSTAL;
    endcase
  end
endmodule

/* hdl/cfd_pkg.sv */
// package: configuration word map, field layout and clock mode encodings
package cfd_pkg;
  // register byte addresses (seven config words, one aligned word each)
  localparam int unsigned      NUM_WORDS       = 7;
  localparam logic [5:0]       ADDR_WORD0      = 6'h00;
  localparam logic [5:0]       ADDR_OSC_WORD   = 6'h00;
  localparam logic [5:0]       ADDR_CTRL       = 6'h1c;
  localparam logic [5:0]       ADDR_STATUS     = 6'h20;
  localparam logic [5:0]       ADDR_READBACK   = 6'h24;
  // oscillator word field positions
  localparam int unsigned      FPR_LSB         = 0;
  localparam int unsigned      FOS_LSB         = 8;
  localparam int unsigned      CKSM_LSB        = 14;
  // control register bit positions
  localparam int unsigned      CTRL_LOAD_BIT   = 0;
  localparam int unsigned      CTRL_PROT_BIT   = 1;
  localparam int unsigned      CTRL_RDIDX_LSB  = 4;
  // reset value of every fuse word: erased state
  localparam logic [15:0]      WORD_RESET      = 16'hffff;
  // power-on load time
  localparam int unsigned      CLK_HZ          = 20000000;
  localparam int unsigned      LOAD_TIME_NS    = 1000;
  localparam int unsigned      LOAD_CYCLES     = (LOAD_TIME_NS * (CLK_HZ / 1000000) + 999) / 1000;
  // axi answers
  localparam logic [1:0]       RESP_OKAY       = 2'h0;
  localparam logic [1:0]       RESP_SLVERR     = 2'h2;

  typedef enum logic [3:0] {
    SRC_PRIMARY   = 4'h1,
    SRC_LPRC      = 4'h2,
    SRC_FAST_RC   = 4'h4,
    SRC_SEC_32K   = 4'h8
  } cfd_src_type;

  typedef enum logic [6:0] {
    MODE_EXT_CLK_PIN_FREE = 7'h01,
    MODE_EXT_CLK_OUT      = 7'h02,
    MODE_EXT_RC_CLKOUT    = 7'h04,
    MODE_EXT_RC_PIN_FREE  = 7'h08,
    MODE_MED_CRYSTAL      = 7'h10,
    MODE_HS_CRYSTAL       = 7'h20,
    MODE_LF_CRYSTAL       = 7'h40
  } cfd_mode_type;
endpackage

/* sim/cfd_eeprom_model.sv */
// data eeprom model behind the read-back port
`timescale 1ns/1ns
module cfd_eeprom_model (
  // read-back port
  input  wire logic [9:0] ee_addr_in,
  output logic      [7:0] ee_data_out
);
  // fixed pattern so every byte is predictable; one byte per address, no bursts
  assign ee_data_out = ee_addr_in[7:0] ^ 8'h5a;
endmodule

/* sim/tb_config_fuse_clock_decode.sv */
// self-checking bench for the configuration loader
`timescale 1ns/1ns
module tb_config_fuse_clock_decode;
  logic                  clk_in, rst_in;
  logic                  awvalid, awready, wvalid, wready, bvalid, bready;
  logic                  arvalid, arready, rvalid, rready;
  logic [5:0]            awaddr, araddr;
  logic [31:0]           wdata, rdata;
  logic [3:0]            wstrb;
  logic [1:0]            bresp, rresp;
  logic [9:0]            ee_addr;
  logic [7:0]            ee_data;
  cfd_pkg::cfd_src_type  src;
  cfd_pkg::cfd_mode_type mode;
  logic [4:0]            pll;
  logic                  sw_en, mon_en, clkout, prot, valid;
  int                    miscompares, checks_done;

  cfd_config_loader i_dut (
    .clk_in(clk_in), .rst_in(rst_in),
    .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_awaddr_in(awaddr),
    .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready), .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb),
    .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready), .s_axi_bresp_out(bresp),
    .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready), .s_axi_araddr_in(araddr),
    .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .ee_addr_out(ee_addr), .ee_data_in(ee_data),
    .reset_src_out(src), .mode_out(mode), .pll_mult_out(pll), .switch_en_out(sw_en),
    .monitor_en_out(mon_en), .second_pin_clkout_out(clkout), .code_protect_out(prot),
    .settings_valid_out(valid)
  );
  cfd_eeprom_model i_ee (.ee_addr_in(ee_addr), .ee_data_out(ee_data));

  initial begin
    clk_in = 0;
    forever #25 clk_in = ~clk_in;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic timed_out(input string name);
    miscompares++;
    $display("[FAIL] %s expected answer seen timeout", name);
    stop_test();
  endtask
  // handshakes judged on settled values at the falling edge, acted on after the rising edge
  task automatic axi_wr(input logic [5:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
    logic ah, wh, bh;
    int n;
    bh = 0;
    @(posedge clk_in);
    awvalid <= 1; awaddr <= a; wvalid <= 1; wdata <= d; wstrb <= s; bready <= 1;
    for (n = 0; n < 50 && !bh; n++) begin
      @(negedge clk_in);
      ah = awvalid & awready; wh = wvalid & wready; bh = bvalid & bready; r = bresp;
      @(posedge clk_in);
      if (ah) awvalid <= 0;
      if (wh) wvalid <= 0;
      if (bh) bready <= 0;
    end
    if (!bh) timed_out("write response");
  endtask
  task automatic axi_rd(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ah, rh;
    int n;
    rh = 0;
    @(posedge clk_in);
    arvalid <= 1; araddr <= a; rready <= 1;
    for (n = 0; n < 50 && !rh; n++) begin
      @(negedge clk_in);
      ah = arvalid & arready; rh = rvalid & rready; d = rdata; r = rresp;
      @(posedge clk_in);
      if (ah) arvalid <= 0;
      if (rh) rready <= 0;
    end
    if (!rh) timed_out("read data");
  endtask
  task automatic power_on();
    @(posedge clk_in);
    rst_in <= 1;
    repeat (4) @(posedge clk_in);
    rst_in <= 0;
  endtask
  task automatic wait_loaded();
    int n;
    for (n = 0; n < 60 && valid !== 1'b1; n++) @(negedge clk_in);
    if (valid !== 1'b1) timed_out("settings load");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    logic [31:0] d, sum;
    logic [1:0]  r;
    sum = 0;
    power_on();
    axi_rd(6'h28, d, r);
    chk("unmapped resp", 32'(cfd_pkg::RESP_SLVERR), 32'(r));
    chk("unmapped data", 32'h0, d);
    axi_wr(6'h0c, 32'h0000ffff, 4'h3, r);
    axi_wr(6'h0c, 32'h0000a5c3, 4'h3, r);
    chk("word3 write resp", 32'(cfd_pkg::RESP_OKAY), 32'(r));
    for (int i = 0; i < 7; i++) begin
      axi_rd(6'(4 * i), d, r);
      chk("word read", (i == 3) ? 32'h0000a5c3 : 32'(cfd_pkg::WORD_RESET), d);
      sum = sum + d;
    end
    chk("checksum", 32'h0000a5c3 + 32'(6 * 16'hffff), sum);
    axi_wr(cfd_pkg::ADDR_CTRL, 32'h2, 4'h1, r);
    chk("protect level", 32'h1, 32'(prot));
    axi_wr(6'h08, 32'h00001234, 4'h3, r);
    chk("protected write", 32'(cfd_pkg::RESP_SLVERR), 32'(r));
    axi_rd(6'h0c, d, r);
    chk("protected read", 32'h0, d);
    chk("protected resp", 32'(cfd_pkg::RESP_OKAY), 32'(r));
    $display("register test done");
  endtask
  task automatic t_readback();
    logic [31:0] d;
    logic [1:0]  r;
    logic [9:0]  p;
    power_on();
    axi_wr(cfd_pkg::ADDR_READBACK, 32'h00000500, 4'hf, r);
    for (int i = 0; i < 3; i++) begin
      p = 10'h005 + 10'(i);
      axi_rd(cfd_pkg::ADDR_READBACK, d, r);
      chk("readback", 32'({p, p[7:0] ^ 8'h5a}), d);
    end
    $display("readback test done");
  endtask
  task automatic t_decode(input logic [1:0] ck, input logic [1:0] fs, input logic [3:0] fp,
      input cfd_pkg::cfd_src_type es, input cfd_pkg::cfd_mode_type em, input logic [4:0] ep, input logic eo);
    logic [1:0]  r;
    logic [15:0] w;
    w = {ck, 4'hf, fs, 4'hf, fp};
    power_on();
    axi_wr(cfd_pkg::ADDR_OSC_WORD, 32'(w), 4'h3, r);
    chk("valid before load", 32'h0, 32'(valid));
    wait_loaded();
    chk("reset source", 32'(es), 32'(src));
    chk("mode", 32'(em), 32'(mode));
    chk("pll", 32'(ep), 32'(pll));
    chk("switch", 32'(!ck[1]), 32'(sw_en));
    chk("monitor", 32'(ck == 2'b00), 32'(mon_en));
    chk("clkout", 32'(eo), 32'(clkout));
    $display("decode test done for word %h", w);
  endtask
  task automatic t_hold();
    logic [31:0] d;
    logic [1:0]  r;
    axi_wr(cfd_pkg::ADDR_OSC_WORD, 32'h0000ffff, 4'h3, r);
    repeat (5) @(posedge clk_in);
    chk("held mode", 32'(cfd_pkg::MODE_LF_CRYSTAL), 32'(mode));
    chk("held source", 32'(cfd_pkg::SRC_SEC_32K), 32'(src));
    axi_rd(cfd_pkg::ADDR_STATUS, d, r);
    chk("status", 32'h00000003, d);
    $display("hold test done");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    miscompares = 0; checks_done = 0; rst_in = 1;
    awvalid = 0; awaddr = 0; wvalid = 0; wdata = 0; wstrb = 0; bready = 0;
    arvalid = 0; araddr = 0; rready = 0;
    repeat (4) @(posedge clk_in);
    rst_in <= 0;
    t_readback();
    t_regs();
    // code 1010 is never written by the programmer side
    t_decode(2'b10, 2'b11, 4'hf, cfd_pkg::SRC_PRIMARY, cfd_pkg::MODE_EXT_CLK_PIN_FREE, 5'h10, 0);
    t_decode(2'b01, 2'b10, 4'he, cfd_pkg::SRC_LPRC, cfd_pkg::MODE_EXT_CLK_PIN_FREE, 5'h08, 0);
    t_decode(2'b00, 2'b01, 4'hd, cfd_pkg::SRC_FAST_RC, cfd_pkg::MODE_EXT_CLK_PIN_FREE, 5'h04, 0);
    t_decode(2'b11, 2'b00, 4'hc, cfd_pkg::SRC_SEC_32K, cfd_pkg::MODE_EXT_CLK_PIN_FREE, 5'h01, 0);
    t_decode(2'b10, 2'b11, 4'hb, cfd_pkg::SRC_PRIMARY, cfd_pkg::MODE_EXT_CLK_OUT, 5'h01, 1);
    t_decode(2'b01, 2'b11, 4'h9, cfd_pkg::SRC_PRIMARY, cfd_pkg::MODE_EXT_RC_CLKOUT, 5'h01, 1);
    t_decode(2'b00, 2'b11, 4'h8, cfd_pkg::SRC_PRIMARY, cfd_pkg::MODE_EXT_RC_PIN_FREE, 5'h01, 0);
    t_decode(2'b10, 2'b11, 4'h7, cfd_pkg::SRC_PRIMARY, cfd_pkg::MODE_MED_CRYSTAL, 5'h10, 0);
    t_decode(2'b10, 2'b11, 4'h6, cfd_pkg::SRC_PRIMARY, cfd_pkg::MODE_MED_CRYSTAL, 5'h08, 0);
    t_decode(2'b10, 2'b11, 4'h5, cfd_pkg::SRC_PRIMARY, cfd_pkg::MODE_MED_CRYSTAL, 5'h04, 0);
    t_decode(2'b10, 2'b11, 4'h4, cfd_pkg::SRC_PRIMARY, cfd_pkg::MODE_MED_CRYSTAL, 5'h01, 0);
    t_decode(2'b10, 2'b11, 4'h3, cfd_pkg::SRC_PRIMARY, cfd_pkg::MODE_HS_CRYSTAL, 5'h01, 0);
    t_decode(2'b10, 2'b11, 4'h2, cfd_pkg::SRC_PRIMARY, cfd_pkg::MODE_HS_CRYSTAL, 5'h01, 0);
    t_decode(2'b10, 2'b11, 4'h1, cfd_pkg::SRC_PRIMARY, cfd_pkg::MODE_LF_CRYSTAL, 5'h01, 0);
    t_decode(2'b10, 2'b00, 4'h0, cfd_pkg::SRC_SEC_32K, cfd_pkg::MODE_LF_CRYSTAL, 5'h01, 0);
    t_hold();
    stop_test();
  end
endmodule
